// >>> src/sram_fifo_defines.svh
`ifndef SRAM_FIFO_DEFINES_SVH
`define SRAM_FIFO_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_DEPTH       8'h04
`define REG_AE_THR      8'h08
`define REG_AF_THR      8'h0c
`define REG_STATUS      8'h10
`define REG_IRQ_STATUS  8'h14
`define REG_IRQ_CLEAR   8'h18
`define REG_IRQ_ENABLE  8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_FIFO_BIT   0
`define CTRL_WRW_LSB    1
`define CTRL_RDW_LSB    4
`define STAT_COUNT_LSB  16
`define IRQ_OVERFLOW    0
`define IRQ_UNDERFLOW   1
`define IRQ_ALMOST_FULL  2
`define IRQ_ALMOST_EMPTY 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST        32'h0000_0048
`define DEPTH_RST       13'h0100
`define AE_THR_RST      13'h0004
`define AF_THR_RST      13'h00fc
`define IRQ_ENABLE_RST  4'h0

`endif

// >>> src/sram_fifo_pkg.sv
package sram_fifo_pkg;

    typedef enum logic [2:0] {
        W1  = 3'b000,
        W2  = 3'b001,
        W4  = 3'b010,
        W9  = 3'b011,
        W18 = 3'b100
    } width_t;

    typedef struct packed {
        logic        req;
        logic        sel;
        logic [11:0] addr;
        logic [17:0] data;
    } wr_port_t;

    typedef struct packed {
        logic        req;
        logic        sel;
        logic [11:0] addr;
    } rd_port_t;

    typedef struct packed {
        logic empty;
        logic full;
        logic almost_empty_flag;
        logic almost_full_flag;
    } fifo_flags_t;

    typedef struct packed {
        logic [7:0] row;
        logic [4:0] col;
    } loc_t;

endpackage : sram_fifo_pkg

// >>> src/sram_fifo_block.sv
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "sram_fifo_defines.svh"

module sram_fifo_block #(
    parameter int ROWS  = 256,
    parameter int ROW_W = 18
) (
    input  logic                       clk,        // 100 MHz clock
    input  logic                       rst_b,      // async reset
    input  logic [7:0]                 reg_addr,   // register byte address
    input  logic [31:0]                reg_wdata,  // register write data
    input  logic                       reg_wr,     // register write strobe
    input  logic                       reg_rd,     // register read strobe
    output logic [31:0]                reg_rdata,  // read data, next cycle
    input  sram_fifo_pkg::wr_port_t    wr_port,    // write port
    input  sram_fifo_pkg::rd_port_t    rd_port,    // read port
    output logic [17:0]                rd_data,    // read data, next cycle
    output logic                       rd_valid,   // rd_data holds a read
    output sram_fifo_pkg::fifo_flags_t flags,      // fifo status flags
    input  logic                       pl_we,      // preload row strobe
    input  logic [7:0]                 pl_row,     // preload row
    input  logic [17:0]                pl_data,    // preload row data
    output logic                       irq         // level interrupt
);

    // ----------------------------------------------------------------
    // shape helpers
    // ----------------------------------------------------------------
    function automatic sram_fifo_pkg::loc_t loc_of(sram_fifo_pkg::width_t w, logic [11:0] a);
        sram_fifo_pkg::loc_t l;
        l = '0;
        case (w)
            sram_fifo_pkg::W1: begin
                l.row = a[11:4];
                l.col = {1'b0, a[3:0]};
            end
            sram_fifo_pkg::W2: begin
                l.row = a[10:3];
                l.col = {1'b0, a[2:0], 1'b0};
            end
            sram_fifo_pkg::W4: begin
                l.row = a[9:2];
                l.col = {1'b0, a[1:0], 2'b00};
            end
            sram_fifo_pkg::W9: begin
                l.row = a[8:1];
                l.col = a[0] ? 5'h09 : 5'h00;
            end
            default: begin
                l.row = a[7:0];
                l.col = 5'h00;
            end
        endcase
        return l;
    endfunction : loc_of

    function automatic logic [17:0] mask_of(sram_fifo_pkg::width_t w);
        case (w)
            sram_fifo_pkg::W1: return 18'h00001;
            sram_fifo_pkg::W2: return 18'h00003;
            sram_fifo_pkg::W4: return 18'h0000f;
            sram_fifo_pkg::W9: return 18'h001ff;
            default:           return 18'h3ffff;
        endcase
    endfunction : mask_of

    function automatic logic [12:0] words_of(sram_fifo_pkg::width_t w);
        case (w)
            sram_fifo_pkg::W1: return 13'h1000;
            sram_fifo_pkg::W2: return 13'h0800;
            sram_fifo_pkg::W4: return 13'h0400;
            sram_fifo_pkg::W9: return 13'h0200;
            default:           return 13'h0100;
        endcase
    endfunction : words_of

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [ROW_W-1:0]      mem [ROWS];
    logic                  fifo_mode;
    sram_fifo_pkg::width_t cfg_wr;
    sram_fifo_pkg::width_t cfg_rd;
    logic [12:0]           cfg_depth;
    logic [12:0]           ae_thr;
    logic [12:0]           af_thr;
    logic [11:0]           wptr;
    logic [11:0]           rptr;
    logic [12:0]           count;
    logic [3:0]            irq_sts;
    logic [3:0]            irq_en;
    logic                  almost_full_q;
    logic                  almost_empty_q;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire wr_ctrl  = reg_wr && reg_addr == `REG_CTRL;
    wire wr_depth = reg_wr && reg_addr == `REG_DEPTH;
    wire wr_ae    = reg_wr && reg_addr == `REG_AE_THR;
    wire wr_af    = reg_wr && reg_addr == `REG_AF_THR;
    wire wr_clr   = reg_wr && reg_addr == `REG_IRQ_CLEAR;
    wire wr_en    = reg_wr && reg_addr == `REG_IRQ_ENABLE;
    wire flush    = wr_ctrl || wr_depth;

    // ----------------------------------------------------------------
    // fifo control
    // ----------------------------------------------------------------
    // fifo uses the write-port width on both sides
    wire sram_fifo_pkg::width_t rd_w = fifo_mode ? cfg_wr : cfg_rd;
    wire [12:0] max_words = words_of(cfg_wr);
    wire [12:0] depth     = (cfg_depth == 13'h0 || cfg_depth > max_words) ? max_words : cfg_depth;
    wire [11:0] last_idx  = 12'(depth - 13'h1);

    wire is_empty  = count == 13'h0;
    wire is_full   = count == depth;
    wire is_almost_empty = count <= ae_thr;
    wire is_almost_full  = count >= af_thr;

    wire wr_try = wr_port.req && wr_port.sel && !pl_we;
    wire rd_try = rd_port.req && rd_port.sel;
    wire wr_ok  = wr_try && !(fifo_mode && is_full);
    wire rd_ok  = rd_try && !(fifo_mode && is_empty);
    wire f_wr   = fifo_mode && wr_ok;
    wire f_rd   = fifo_mode && rd_ok;

    wire [11:0] next_wptr  = (wptr == last_idx) ? 12'h000 : 12'(wptr + 12'h1);
    wire [11:0] next_rptr  = (rptr == last_idx) ? 12'h000 : 12'(rptr + 12'h1);
    wire [12:0] next_count = 13'(count + {12'h0, f_wr} - {12'h0, f_rd});

    // ----------------------------------------------------------------
    // memory datapath
    // ----------------------------------------------------------------
    wire [11:0] waddr = fifo_mode ? wptr : wr_port.addr;
    wire [11:0] raddr = fifo_mode ? rptr : rd_port.addr;
    wire sram_fifo_pkg::loc_t wloc = loc_of(cfg_wr, waddr);
    wire sram_fifo_pkg::loc_t rloc = loc_of(rd_w, raddr);
    wire [17:0] wmask    = mask_of(cfg_wr);
    wire [17:0] rmask    = mask_of(rd_w);
    wire [17:0] wmask_sh = 18'(wmask << wloc.col);
    wire [17:0] wdata_sh = 18'((wr_port.data & wmask) << wloc.col);
    wire [17:0] next_row = (mem[wloc.row] & ~wmask_sh) | (wdata_sh & wmask_sh);
    wire [17:0] rd_word  = 18'((mem[rloc.row] >> rloc.col) & rmask);

    // 256 rows of 18 bits: 4,608 bits, of which the 1-, 2- and 4-bit shapes reach only 4,096
    always_ff @(posedge clk) begin
        if (pl_we) begin
            mem[pl_row] <= pl_data;
        end else if (wr_ok) begin
            mem[wloc.row] <= next_row;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data  <= 18'h00000;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= rd_ok ? rd_word : rd_data;
            rd_valid <= rd_ok;
        end
    end

    // ----------------------------------------------------------------
    // pointers and configuration
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr  <= 12'h000;
            rptr  <= 12'h000;
            count <= 13'h0000;
        end else if (flush) begin
            wptr  <= 12'h000;
            rptr  <= 12'h000;
            count <= 13'h0000;
        end else begin
            wptr  <= f_wr ? next_wptr : wptr;
            rptr  <= f_rd ? next_rptr : rptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_mode <= 1'(`CTRL_RST >> `CTRL_FIFO_BIT);
            cfg_wr    <= sram_fifo_pkg::width_t'(3'(`CTRL_RST >> `CTRL_WRW_LSB));
            cfg_rd    <= sram_fifo_pkg::width_t'(3'(`CTRL_RST >> `CTRL_RDW_LSB));
            cfg_depth <= `DEPTH_RST;
            ae_thr    <= `AE_THR_RST;
            af_thr    <= `AF_THR_RST;
        end else begin
            if (wr_ctrl) begin
                fifo_mode <= reg_wdata[`CTRL_FIFO_BIT];
                cfg_wr    <= sram_fifo_pkg::width_t'(reg_wdata[`CTRL_WRW_LSB +: 3]);
                cfg_rd    <= sram_fifo_pkg::width_t'(reg_wdata[`CTRL_RDW_LSB +: 3]);
            end
            cfg_depth <= wr_depth ? reg_wdata[12:0] : cfg_depth;
            ae_thr    <= wr_ae ? reg_wdata[12:0] : ae_thr;
            af_thr    <= wr_af ? reg_wdata[12:0] : af_thr;
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    wire [3:0] evt;
    assign evt[`IRQ_OVERFLOW]  = fifo_mode && wr_try && is_full;
    assign evt[`IRQ_UNDERFLOW] = fifo_mode && rd_try && is_empty;
    assign evt[`IRQ_ALMOST_FULL]  = fifo_mode && is_almost_full && !almost_full_q;
    assign evt[`IRQ_ALMOST_EMPTY] = fifo_mode && is_almost_empty && !almost_empty_q;
    wire [3:0] clr = wr_clr ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_sts  <= 4'h0;
            irq_en   <= `IRQ_ENABLE_RST;
            almost_full_q  <= 1'b0;
            almost_empty_q <= 1'b0;
        end else begin
            irq_sts  <= (irq_sts & ~clr) | evt;
            irq_en   <= wr_en ? reg_wdata[3:0] : irq_en;
            almost_full_q  <= is_almost_full;
            almost_empty_q <= is_almost_empty;
        end
    end

    assign irq   = |(irq_sts & irq_en);
    assign flags = '{empty: is_empty, full: is_full,
                     almost_empty_flag: is_almost_empty, almost_full_flag: is_almost_full};

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    wire [31:0] ctrl_word = {25'h0, 3'(cfg_rd), 3'(cfg_wr), fifo_mode};
    wire [31:0] stat_word = {3'h0, count, 12'h0, is_almost_full, is_almost_empty, is_full, is_empty};
    wire [31:0] rd_mux =
        (reg_addr == `REG_CTRL)       ? ctrl_word :
        (reg_addr == `REG_DEPTH)      ? {19'h0, cfg_depth} :
        (reg_addr == `REG_AE_THR)     ? {19'h0, ae_thr} :
        (reg_addr == `REG_AF_THR)     ? {19'h0, af_thr} :
        (reg_addr == `REG_STATUS)     ? stat_word :
        (reg_addr == `REG_IRQ_STATUS) ? {28'h0, irq_sts} :
        (reg_addr == `REG_IRQ_ENABLE) ? {28'h0, irq_en} : 32'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [3:0]  nib_q;
    logic [11:0] nib_addr_q;
    logic [1:0]  bit_sel_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nib_q      <= 4'h0;
            nib_addr_q <= 12'h000;
            bit_sel_q  <= 2'h0;
        end else begin
            nib_q      <= wr_ok ? wr_port.data[3:0] : nib_q;
            nib_addr_q <= wr_ok ? wr_port.addr : nib_addr_q;
            bit_sel_q  <= rd_port.addr[1:0];
        end
    end

    sequence s_nib_write;
        !fifo_mode && wr_ok && cfg_wr == sram_fifo_pkg::W4;
    endsequence
    sequence s_bit_read;
        !fifo_mode && rd_ok && !wr_ok && !pl_we && cfg_rd == sram_fifo_pkg::W1 &&
        rd_port.addr[11:2] == nib_addr_q[9:0];
    endsequence
    sequence s_preload;
        pl_we && !fifo_mode;
    endsequence
    sequence s_row_read;
        !fifo_mode && rd_ok && !wr_ok && !pl_we && cfg_rd == sram_fifo_pkg::W18 &&
        rd_port.addr[7:0] == $past(pl_row, 2) && !flush;
    endsequence

    a_full_blocks_wr: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_mode && is_full && wr_try && !rd_ok && !flush |=> $stable(wptr) && count == depth)
        else $error("write taken while fifo full");
    a_empty_blocks_rd: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_mode && is_empty && rd_try && !f_wr && !flush |=> $stable(rptr) && !rd_valid)
        else $error("read taken while fifo empty");
    a_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        f_wr && wptr == last_idx && !flush |=> wptr == 12'h000)
        else $error("write pointer did not wrap");
    a_ptr_advance: assert property (@(posedge clk) disable iff (!rst_b)
        f_rd && rptr != last_idx && !flush |=> rptr == $past(rptr) + 12'h1)
        else $error("read pointer did not advance");
    a_full_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        f_wr && !f_rd && count == depth - 13'h1 && !flush |=> flags.full && !flags.empty)
        else $error("full flag missing after last write");
    a_count_in_depth: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_mode && !$past(flush) |-> count <= depth)
        else $error("fill level beyond depth");
    a_serial_bits: assert property (@(posedge clk) disable iff (!rst_b)
        s_nib_write ##1 (!wr_ok && !pl_we) ##1 s_bit_read |=> rd_data[0] == nib_q[bit_sel_q])
        else $error("bit read does not match nibble written");
    a_preload_row: assert property (@(posedge clk) disable iff (!rst_b)
        s_preload ##1 (!wr_ok && !pl_we) ##1 s_row_read |=> rd_data == $past(pl_data, 3))
        else $error("preloaded row not read back");
    a_overflow_irq: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_mode && is_full && wr_try |=> irq_sts[`IRQ_OVERFLOW] && (irq || !irq_en[`IRQ_OVERFLOW]))
        else $error("overflow not flagged");
    a_underflow_irq: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_mode && is_empty && rd_try |=> irq_sts[`IRQ_UNDERFLOW])
        else $error("underflow not flagged");
    a_empty_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        f_rd && !f_wr && count == 13'h1 && !flush |=> flags.empty && !flags.full)
        else $error("empty flag missing after last read");
    a_rd_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        f_rd && rptr == last_idx && !flush |=> rptr == 12'h000)
        else $error("read pointer did not wrap");
    a_wr_ptr_advance: assert property (@(posedge clk) disable iff (!rst_b)
        f_wr && wptr != last_idx && !flush |=> wptr == $past(wptr) + 12'h1)
        else $error("write pointer did not advance");
    a_flush_clears: assert property (@(posedge clk) disable iff (!rst_b)
        flush |=> count == 13'h0 && wptr == 12'h000 && rptr == 12'h000)
        else $error("settings change did not empty the fifo");

endmodule : sram_fifo_block

// >>> tb/fabric_model.sv
`timescale 1ns/1ps
module fabric_model (
    input  logic                    clk,      // bench clock
    output sram_fifo_pkg::wr_port_t wr_port,  // to write port
    output sram_fifo_pkg::rd_port_t rd_port,  // to read port
    input  logic [17:0]             rd_data,  // read data back
    input  logic                    rd_valid  // read accepted
);
    // ----------------------------------------------------------------
    // user fabric driving both ports
    // ----------------------------------------------------------------
    initial begin
        wr_port = '0;
        rd_port = '0;
    end

    // released address and data lines show the inverse of the last value, req and sel drop to 0
    task automatic wr_op(input logic sel, input logic [11:0] addr, input logic [17:0] data);
        @(posedge clk);
        wr_port <= '{req: 1'b1, sel: sel, addr: addr, data: data};
        @(posedge clk);
        wr_port <= '{req: 1'b0, sel: 1'b0, addr: ~addr, data: ~data};
    endtask : wr_op

    task automatic rd_op(input logic sel, input logic [11:0] addr, output logic [17:0] data, output logic valid);
        @(posedge clk);
        rd_port <= '{req: 1'b1, sel: sel, addr: addr};
        @(posedge clk);
        rd_port <= '{req: 1'b0, sel: 1'b0, addr: ~addr};
        #1;
        data  = rd_data;
        valid = rd_valid;
    endtask : rd_op
endmodule : fabric_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "sram_fifo_defines.svh"
module tb;
    logic                       clk       = 1'b0;
    logic                       rst_b     = 1'b0;
    logic [7:0]                 reg_addr  = 8'h00;
    logic [31:0]                reg_wdata = 32'h0;
    logic                       reg_wr    = 1'b0;
    logic                       reg_rd    = 1'b0;
    logic [31:0]                reg_rdata;
    sram_fifo_pkg::wr_port_t    wr_port;
    sram_fifo_pkg::rd_port_t    rd_port;
    logic [17:0]                rd_data;
    logic                       rd_valid;
    sram_fifo_pkg::fifo_flags_t flags;
    logic                       pl_we     = 1'b0;
    logic [7:0]                 pl_row    = 8'h00;
    logic [17:0]                pl_data   = 18'h0;
    logic                       irq;
    int                         error_cnt = 0;
    int                         n_checks  = 0;
    int                         ram [int];
    int                         fifo_q [$];
    int                         wbits [5] = '{1, 2, 4, 9, 18};
    int                         wdep [5]  = '{4096, 2048, 1024, 512, 256};
    int                         rounds [3] = '{9, 5, 9};
    int                         a;
    int                         e;
    int                         ed;
    logic [31:0]                d;
    logic [17:0]                mask;
    logic [17:0]                got;
    logic                       vld;

    always #5 clk = ~clk;

    sram_fifo_block u_sram_fifo_block (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wr_port(wr_port),
        .rd_port(rd_port), .rd_data(rd_data), .rd_valid(rd_valid), .flags(flags),
        .pl_we(pl_we), .pl_row(pl_row), .pl_data(pl_data), .irq(irq)
    );

    fabric_model u_fabric_model (
        .clk(clk), .wr_port(wr_port), .rd_port(rd_port), .rd_data(rd_data), .rd_valid(rd_valid)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= adr;
        reg_wdata <= wd;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input string name, input logic [7:0] adr, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= adr;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask : reg_check

    task automatic flag_check(input int cnt, input int dep, input int ae, input int af);
        check("flags", {28'h0, flags}, {28'h0, cnt == 0, cnt == dep, cnt <= ae, cnt >= af});
    endtask : flag_check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h2026));
        repeat (10) @(posedge clk);
        flag_check(0, 256, 4, 252);
        check("irq", {31'h0, irq}, 32'h0);
        rst_b <= 1'b1;
        reg_check("ctrl", `REG_CTRL, 32'h48);
        reg_check("depth", `REG_DEPTH, 32'h100);
        reg_check("ae_thr", `REG_AE_THR, 32'h4);
        reg_check("af_thr", `REG_AF_THR, 32'hfc);
        reg_check("irq_en", `REG_IRQ_ENABLE, 32'h0);
        reg_check("unmapped", 8'h20, 32'h0);
        // every shape, top address included
        for (int w = 0; w < 5; w++) begin
            reg_write(`REG_CTRL, (w << 4) | (w << 1));
            ram.delete();
            mask = 18'((1 << wbits[w]) - 1);
            for (int k = 0; k < 6; k++) begin
                a = (k == 0) ? wdep[w] - 1 : int'($urandom % wdep[w]);
                d = $urandom & 32'(mask);
                u_fabric_model.wr_op(1'b1, a[11:0], d[17:0]);
                ram[a] = d;
            end
            foreach (ram[i]) begin
                u_fabric_model.rd_op(1'b1, 12'(i), got, vld);
                check("ram_word", {13'h0, vld, got & mask}, {14'h1, 18'(ram[i])});
            end
        end
        // 4-bit writes read as a bitstream
        reg_write(`REG_CTRL, 32'h04);
        a = $urandom % 1024;
        d = $urandom & 32'hf;
        u_fabric_model.wr_op(1'b1, a[11:0], d[17:0]);
        for (int k = 0; k < 4; k++) begin
            u_fabric_model.rd_op(1'b1, 12'(4 * a + k), got, vld);
            check("bitstream", {30'h0, vld, got[0]}, {30'h0, 1'b1, d[k]});
        end
        // block select and preload
        reg_write(`REG_CTRL, 32'h48);
        u_fabric_model.wr_op(1'b1, 12'h007, 18'h2a5a5);
        u_fabric_model.wr_op(1'b0, 12'h007, 18'h15a5a);
        u_fabric_model.rd_op(1'b1, 12'h007, got, vld);
        check("sel_write", {13'h0, vld, got}, {14'h1, 18'h2a5a5});
        u_fabric_model.rd_op(1'b0, 12'h007, got, vld);
        check("sel_read", {31'h0, vld}, 32'h0);
        d = $urandom & 32'h3ffff;
        @(posedge clk);
        pl_we   <= 1'b1;
        pl_row  <= 8'h33;
        pl_data <= d[17:0];
        @(posedge clk);
        pl_we   <= 1'b0;
        pl_data <= ~d[17:0];
        u_fabric_model.rd_op(1'b1, 12'h033, got, vld);
        check("preload", {13'h0, vld, got}, {14'h1, d[17:0]});
        // fifo of depth 8, crossing the pointer wrap
        reg_write(`REG_DEPTH, 32'h8);
        reg_write(`REG_AE_THR, 32'h2);
        reg_write(`REG_AF_THR, 32'h6);
        reg_write(`REG_CTRL, 32'h49);
        repeat (2) @(posedge clk);
        reg_write(`REG_IRQ_CLEAR, 32'hf);
        reg_check("irq_st0", `REG_IRQ_STATUS, 32'h0);
        foreach (rounds[r]) begin
            for (int k = 0; k < rounds[r]; k++) begin
                d = $urandom & 32'h3ffff;
                u_fabric_model.wr_op(1'b1, 12'($urandom), d[17:0]);
                if (fifo_q.size() < 8) fifo_q.push_back(int'(d));
                #1;
                flag_check(fifo_q.size(), 8, 2, 6);
            end
            d = 32'(fifo_q.size() << `STAT_COUNT_LSB);
            d[3:0] = {fifo_q.size() >= 6, fifo_q.size() <= 2, fifo_q.size() == 8, fifo_q.size() == 0};
            reg_check("status", `REG_STATUS, d);
            for (int k = 0; k < rounds[r]; k++) begin
                u_fabric_model.rd_op(1'b1, 12'($urandom), got, vld);
                e  = fifo_q.size() > 0;
                ed = (e != 0) ? fifo_q.pop_front() : 0;
                check("fifo_pop", {13'h0, vld, vld ? got : 18'h0}, {13'h0, e[0], ed[17:0]});
                flag_check(fifo_q.size(), 8, 2, 6);
            end
        end
        // interrupt: sticky, masked, cleared
        reg_check("irq_st", `REG_IRQ_STATUS, 32'hf);
        check("irq_masked", {31'h0, irq}, 32'h0);
        reg_write(`REG_IRQ_ENABLE, 32'h1);
        #1;
        check("irq_on", {31'h0, irq}, 32'h1);
        reg_write(`REG_IRQ_CLEAR, 32'h1);
        #1;
        check("irq_off", {31'h0, irq}, 32'h0);
        reg_check("irq_st1", `REG_IRQ_STATUS, 32'he);
        reg_check("irq_clr_rd", `REG_IRQ_CLEAR, 32'h0);
        report_and_stop();
    end
endmodule : tb
